// [logic/sog_pkg.sv]
// shared constants and types of the switchgear object controller
package sog_pkg;
  localparam int AW       = 8;
  localparam int DW       = 32;
  localparam int TW       = 16;
  localparam int DLY_W    = 21;
  localparam int CLK_NS   = 10;
  localparam int MS_NS    = 1000000;
  localparam int OP_DEPTH = 12;
  localparam int RT_W     = 4;
  localparam logic [AW-1:0] REG_CTRL    = 8'h00;
  localparam logic [AW-1:0] REG_CMD     = 8'h04;
  localparam logic [AW-1:0] REG_STATUS  = 8'h08;
  localparam logic [AW-1:0] REG_EVT     = 8'h0C;
  localparam logic [AW-1:0] REG_EVMASK  = 8'h10;
  localparam logic [AW-1:0] REG_IRQMASK = 8'h14;
  localparam logic [AW-1:0] REG_TRAV    = 8'h18;
  localparam logic [AW-1:0] REG_PL_OPEN = 8'h1C;
  localparam logic [AW-1:0] REG_PL_CLS  = 8'h20;
  localparam logic [AW-1:0] REG_TERM    = 8'h24;
  localparam logic [AW-1:0] REG_BLOCK   = 8'h28;
  localparam logic [AW-1:0] REG_DIPOL   = 8'h2C;
  localparam logic [AW-1:0] REG_DOPOL   = 8'h30;
  localparam logic [AW-1:0] REG_ROUTE   = 8'h34;
  localparam logic [AW-1:0] REG_CNT_REQ = 8'h38;
  localparam logic [AW-1:0] REG_CNT_FL  = 8'h3C;
  localparam logic [AW-1:0] REG_OP_IDX  = 8'h40;
  localparam logic [AW-1:0] REG_OP_DATA = 8'h44;
  localparam logic [AW-1:0] DI_ACT_BASE = 8'h80;
  localparam logic [AW-1:0] DI_REL_BASE = 8'hC0;
  localparam int CB_REMOTE = 0;
  localparam int CB_USE_SYNC = 1;
  localparam int CB_USE_READY = 2;
  localparam int CB_CLR_REGS = 3;
  localparam int CB_CLR_STATS = 4;
  localparam int CB_LATCH_CLR = 5;
  localparam int CB_SOFT_RST = 6;
  localparam int CM_OPEN = 0;
  localparam int CM_CLOSE = 1;
  localparam int BS_EXT = 8;
  localparam int BS_BAD = 16;
  localparam int SR_FAIL = 2;
  localparam int SR_BUSY = 3;
  localparam int SR_DI = 8;
  localparam int EV_OPEN_REQ = 0;
  localparam int EV_CLOSE_REQ = 1;
  localparam int EV_OPEN_FAIL = 2;
  localparam int EV_CLOSE_FAIL = 3;
  localparam int EV_STATUS = 4;
  localparam int EV_REJECT = 5;
  localparam int EV_W = 6;
  localparam int DI_ST_OPEN = 0;
  localparam int DI_ST_CLOSED = 1;
  localparam int DI_LOC_OPEN = 2;
  localparam int DI_LOC_CLOSE = 3;
  localparam int DI_REM_OPEN = 4;
  localparam int DI_REM_CLOSE = 5;
  localparam int DI_READY = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_MID = 2'b00, ST_OPEN = 2'b01, ST_CLOSED = 2'b10, ST_BAD = 2'b11
  } sog_objst_type;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_OPEN = 2'b01, S_CLOSE = 2'b10
  } sog_state_type;
  typedef struct packed {
    logic          valid;
    logic          is_close;
    logic          failed;
    logic [TW-1:0] time_ms;
  } sog_oprec_type;
endpackage : sog_pkg

// [logic/sog_object_ctrl.sv]
// switchgear object control, input conditioning, output matrix and event logic
// How it works
// - hold last end status during traverse time
// - command pulse bounded, cut when status reached
// - no status change by timeout records failure
// - timeout aborts sequence, drops output, flags failure
// - application inputs ignore local/remote selection
// - dedicated inputs for local/remote open/close
// - selectable blocking sources inhibit control
// - each relay output connection latched or not
// - twelve-entry operation ring, cleared on command
// - event masks reset off, gate recording
// - per input polarity, NC inverts level
// - per input activation and release delays
// - per output polarity, resets to NO
// - full reset de-energises outputs, soft reset only ends the command pulse
// - decode status pair: mid, open, closed, bad
// - close needs sync/ready permission when used
// - local mode rejects bus, remote rejects local
// - latched output holds until clear with trigger low
`timescale 1ns/1ps
module sog_object_ctrl #(
  parameter int NDI        = 8,
  parameter int NRLY       = 4,
  parameter int CYC_PER_MS = sog_pkg::MS_NS / sog_pkg::CLK_NS
) (
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  input  wire logic [sog_pkg::AW-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [sog_pkg::DW-1:0] wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [sog_pkg::AW-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [sog_pkg::DW-1:0]      rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic [NDI-1:0]         di_pin,
  input  wire logic                   app_open,
  input  wire logic                   app_close,
  input  wire logic                   sync_ok,
  input  wire logic [7:0]             ext_block,
  output logic                        cmd_open_pin,
  output logic                        cmd_close_pin,
  output logic [NRLY-1:0]             relay,
  output logic                        irq
);
  import sog_pkg::*;

  localparam int PW = $clog2(CYC_PER_MS + 1);
  localparam int NO = NRLY + 2;

  logic [PW-1:0]    pre;
  logic             tick;
  logic [NDI-1:0]   s1, s2, s3, di_st;
  logic [DLY_W-1:0] act_dly [NDI];
  logic [DLY_W-1:0] rel_dly [NDI];
  logic [NDI-1:0]   di_pol;
  logic [NO-1:0]    do_pol, out_pin;
  logic [NRLY*RT_W-1:0] route;
  logic             remote, use_sync, use_ready;
  logic             clr_regs, clr_stats, latch_clr, soft_rst, bus_open, bus_close;
  logic [EV_W-1:0]  evt, evmask, irqmask, ev_new;
  logic [TW-1:0]    trav, pl_open, pl_close, term_to, t_ms, trav_cnt;
  logic [NDI-1:0]   blk_di;
  logic [7:0]       blk_ext;
  logic             blk_bad;
  logic [3:0]       op_idx, wr_ptr;
  sog_oprec_type    oprec [OP_DEPTH];
  logic [TW-1:0]    cnt_open, cnt_close, fl_open, fl_close;
  sog_objst_type    objst_raw, objst_rep;
  sog_state_type    state;
  logic             drive, fail_flag, app_open_q, app_close_q;
  logic [NDI-1:0]   di_q;
  logic [AW-1:0]    aw_addr;
  logic [DW-1:0]    w_data, wv, rd_val;
  logic [3:0]       w_strb;
  logic             do_wr, wr_hit, rd_hit;

  // millisecond time base for every timer of the block
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (pre == PW'(CYC_PER_MS - 1));
      pre <= (pre == PW'(CYC_PER_MS - 1)) ? '0 : pre + 1'b1;
    end
  end

  // pins pass three flops; a level counts once stages two and three agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= di_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  for (genvar i = 0; i < NDI; i++) begin : g_di
    logic             want;
    logic [DLY_W-1:0] cnt;
    assign want = s3[i] ^ di_pol[i];
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        di_st[i] <= 1'b0;
        cnt <= '0;
      end else if (s2[i] != s3[i] || want == di_st[i]) begin
        cnt <= '0;
      end else if (cnt >= (want ? act_dly[i] : rel_dly[i])) begin
        di_st[i] <= want;
        cnt <= '0;
      end else if (tick) begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  assign objst_raw = sog_objst_type'({di_st[DI_ST_CLOSED], di_st[DI_ST_OPEN]});

  // a brief gap while the contacts travel is not reported as intermediate
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      objst_rep <= ST_MID;
      trav_cnt <= '0;
    end else if (objst_raw != ST_MID) begin
      objst_rep <= objst_raw;
      trav_cnt <= '0;
    end else if (trav_cnt >= trav) begin
      objst_rep <= ST_MID;
    end else if (tick) begin
      trav_cnt <= trav_cnt + 1'b1;
    end
  end

  logic req_open, req_close, blocked, perm, go_open, go_close, reject, reached, tmo, stray;
  sog_objst_type tgt;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      di_q <= '0;
      app_open_q <= 1'b0;
      app_close_q <= 1'b0;
    end else begin
      di_q <= di_st;
      app_open_q <= app_open;
      app_close_q <= app_close;
    end
  end

  always_comb begin
    req_open = (app_open & ~app_open_q) |
      (remote ? ((di_st[DI_REM_OPEN] & ~di_q[DI_REM_OPEN]) | bus_open)
              : (di_st[DI_LOC_OPEN] & ~di_q[DI_LOC_OPEN]));
    req_close = (app_close & ~app_close_q) |
      (remote ? ((di_st[DI_REM_CLOSE] & ~di_q[DI_REM_CLOSE]) | bus_close)
              : (di_st[DI_LOC_CLOSE] & ~di_q[DI_LOC_CLOSE]));
    blocked = |(di_st & blk_di) | |(ext_block & blk_ext) | (blk_bad && objst_raw == ST_BAD);
    perm = (!use_sync || sync_ok) && (!use_ready || di_st[DI_READY]);
    // requests from the wrong side are dropped but still reported as refused
    stray = remote ? |(di_st[DI_LOC_CLOSE:DI_LOC_OPEN] & ~di_q[DI_LOC_CLOSE:DI_LOC_OPEN])
                   : |(di_st[DI_REM_CLOSE:DI_REM_OPEN] & ~di_q[DI_REM_CLOSE:DI_REM_OPEN])
                     | bus_open | bus_close;
    go_open = state == S_IDLE && req_open && !blocked && !soft_rst;
    go_close = state == S_IDLE && req_close && !req_open && !blocked && perm && !soft_rst;
    reject = state == S_IDLE && (((req_open || req_close) && !go_open && !go_close) || stray);
    tgt = (state == S_CLOSE) ? ST_CLOSED : ST_OPEN;
    reached = state != S_IDLE && objst_raw == tgt;
    tmo = state != S_IDLE && !reached && t_ms >= term_to;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      drive <= 1'b0;
      t_ms <= '0;
      fail_flag <= 1'b0;
    end else if (soft_rst) begin
      state <= S_IDLE;
      drive <= 1'b0;
      t_ms <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          t_ms <= '0;
          drive <= go_open | go_close;
          if (go_open) begin
            state <= S_OPEN;
          end else if (go_close) begin
            state <= S_CLOSE;
          end
          if (go_open | go_close | clr_stats) begin
            fail_flag <= 1'b0;
          end
        end
        S_OPEN, S_CLOSE: begin
          if (reached || tmo) begin
            state <= S_IDLE;
            drive <= 1'b0;
          end else begin
            drive <= drive && t_ms < (state == S_OPEN ? pl_open : pl_close);
          end
          if (tmo) begin
            fail_flag <= 1'b1;
          end
          if (tick) begin
            t_ms <= t_ms + 1'b1;
          end
        end
        default: begin
          state <= S_IDLE;
          drive <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_open <= '0;
      cnt_close <= '0;
      fl_open <= '0;
      fl_close <= '0;
    end else if (clr_stats) begin
      cnt_open <= '0;
      cnt_close <= '0;
      fl_open <= '0;
      fl_close <= '0;
    end else begin
      cnt_open <= cnt_open + TW'(go_open);
      cnt_close <= cnt_close + TW'(go_close);
      fl_open <= fl_open + TW'(tmo && state == S_OPEN);
      fl_close <= fl_close + TW'(tmo && state == S_CLOSE);
    end
  end

  // operation ring overwrites the oldest entry once full
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      for (int k = 0; k < OP_DEPTH; k++) oprec[k] <= '0;
    end else if (clr_regs) begin
      wr_ptr <= '0;
      for (int k = 0; k < OP_DEPTH; k++) oprec[k] <= '0;
    end else if (reached || tmo) begin
      oprec[wr_ptr] <= '{1'b1, state == S_CLOSE, tmo, t_ms};
      wr_ptr <= (wr_ptr == 4'(OP_DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
  end

  assign ev_new = {reject, objst_rep != objst_raw && objst_raw != ST_MID,
                   tmo && state == S_CLOSE, tmo && state == S_OPEN, go_close, go_open};
  logic rd_evt;
  assign rd_evt = arvalid && arready && araddr == REG_EVT;
  // new event beats a clearing read in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      evt <= '0;
      irq <= 1'b0;
    end else begin
      evt <= (rd_evt ? '0 : evt) | (ev_new & evmask);
      irq <= |(evt & irqmask);
    end
  end

  logic [7:0]    src;
  logic [NO-1:0] out_log;
  assign src = {drive && state == S_CLOSE, drive && state == S_OPEN, blocked, fail_flag,
                objst_rep == ST_BAD, objst_rep == ST_MID,
                objst_rep == ST_CLOSED, objst_rep == ST_OPEN};
  assign out_log[0] = src[6];
  assign out_log[1] = src[7];
  for (genvar r = 0; r < NRLY; r++) begin : g_rly
    logic trig, lat;
    assign trig = src[route[r*RT_W +: 3]];
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        lat <= 1'b0;
      end else if (!route[r*RT_W + 3]) begin
        lat <= 1'b0;
      end else if (trig) begin
        lat <= 1'b1;
      end else if (latch_clr) begin
        lat <= 1'b0;
      end
    end
    assign out_log[r+2] = route[r*RT_W + 3] ? (lat | trig) : trig;
  end

  // only the full reset clears the pin flops; soft reset reaches them only by ending the command pulse
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_pin <= '0;
    end else begin
      out_pin <= out_log ^ do_pol;
    end
  end
  assign cmd_open_pin = out_pin[0];
  assign cmd_close_pin = out_pin[1];
  assign relay = out_pin[NO-1:2];

  function automatic logic [DW-1:0] reg_rd(input logic [AW-1:0] a);
    logic [DW-1:0] v;
    v = '0;
    case (a)
      REG_CTRL: v = DW'({use_ready, use_sync, remote});
      REG_STATUS: v = DW'({di_st, 4'h0, state != S_IDLE, fail_flag, objst_rep}) << 0;
      REG_EVT: v = DW'(evt);
      REG_EVMASK: v = DW'(evmask);
      REG_IRQMASK: v = DW'(irqmask);
      REG_TRAV: v = DW'(trav);
      REG_PL_OPEN: v = DW'(pl_open);
      REG_PL_CLS: v = DW'(pl_close);
      REG_TERM: v = DW'(term_to);
      REG_BLOCK: v = DW'({blk_bad, 7'h0, blk_ext}) << BS_EXT | DW'(blk_di);
      REG_DIPOL: v = DW'(di_pol);
      REG_DOPOL: v = DW'(do_pol);
      REG_ROUTE: v = DW'(route);
      REG_CNT_REQ: v = {cnt_close, cnt_open};
      REG_CNT_FL: v = {fl_close, fl_open};
      REG_OP_IDX: v = DW'(op_idx);
      REG_OP_DATA: v = (op_idx < 4'(OP_DEPTH)) ? DW'(oprec[op_idx]) : '0;
      default: begin
        for (int i = 0; i < NDI; i++) begin
          if (a == DI_ACT_BASE + AW'(4 * i)) v = DW'(act_dly[i]);
          if (a == DI_REL_BASE + AW'(4 * i)) v = DW'(rel_dly[i]);
        end
      end
    endcase
    return v;
  endfunction : reg_rd

  function automatic logic reg_hit(input logic [AW-1:0] a);
    logic h;
    h = (a <= REG_OP_DATA) && (a[1:0] == 2'b00);
    for (int i = 0; i < NDI; i++) begin
      if (a == DI_ACT_BASE + AW'(4 * i) || a == DI_REL_BASE + AW'(4 * i)) h = 1'b1;
    end
    return h;
  endfunction : reg_hit

  always_comb begin
    do_wr = !awready && !wready && !bvalid;
    wr_hit = reg_hit(aw_addr);
    rd_hit = reg_hit(araddr);
    rd_val = reg_rd(araddr);
    for (int b = 0; b < 4; b++) begin
      wv[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : 8'(reg_rd(aw_addr) >> (b*8));
    end
  end

  // write address and data are taken in either order, then answered together
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      {remote, use_sync, use_ready} <= '0;
      {clr_regs, clr_stats, latch_clr, soft_rst, bus_open, bus_close} <= '0;
      evmask <= '0;
      irqmask <= '0;
      {trav, pl_open, pl_close, term_to} <= '0;
      {blk_di, blk_ext, blk_bad} <= '0;
      di_pol <= '0;
      do_pol <= '0;
      route <= '0;
      op_idx <= '0;
      for (int i = 0; i < NDI; i++) begin
        act_dly[i] <= '0;
        rel_dly[i] <= '0;
      end
    end else begin
      {clr_regs, clr_stats, latch_clr, soft_rst, bus_open, bus_close} <= '0;
      if (do_wr) begin
        case (aw_addr)
          REG_CTRL: begin
            remote <= wv[CB_REMOTE];
            use_sync <= wv[CB_USE_SYNC];
            use_ready <= wv[CB_USE_READY];
            clr_regs <= wv[CB_CLR_REGS];
            clr_stats <= wv[CB_CLR_STATS];
            latch_clr <= wv[CB_LATCH_CLR];
            soft_rst <= wv[CB_SOFT_RST];
          end
          REG_CMD: begin
            bus_open <= wv[CM_OPEN];
            bus_close <= wv[CM_CLOSE];
          end
          REG_EVMASK: evmask <= wv[EV_W-1:0];
          REG_IRQMASK: irqmask <= wv[EV_W-1:0];
          REG_TRAV: trav <= wv[TW-1:0];
          REG_PL_OPEN: pl_open <= wv[TW-1:0];
          REG_PL_CLS: pl_close <= wv[TW-1:0];
          REG_TERM: term_to <= wv[TW-1:0];
          REG_BLOCK: begin
            blk_di <= wv[NDI-1:0];
            blk_ext <= wv[BS_EXT +: 8];
            blk_bad <= wv[BS_BAD];
          end
          REG_DIPOL: di_pol <= wv[NDI-1:0];
          REG_DOPOL: do_pol <= wv[NO-1:0];
          REG_ROUTE: route <= wv[NRLY*RT_W-1:0];
          REG_OP_IDX: op_idx <= wv[3:0];
          default: begin
            for (int i = 0; i < NDI; i++) begin
              if (aw_addr == DI_ACT_BASE + AW'(4 * i)) act_dly[i] <= wv[DLY_W-1:0];
              if (aw_addr == DI_REL_BASE + AW'(4 * i)) rel_dly[i] <= wv[DLY_W-1:0];
            end
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  chk_pulse_bound: assert property (drive |-> t_ms <= (state == S_OPEN ? pl_open : pl_close))
    else $error("command pulse past its limit");
  chk_cut_short: assert property (reached && !soft_rst |=> !drive && state == S_IDLE)
    else $error("command not cut on status reached");
  chk_timeout_abort: assert property (tmo && !soft_rst |=> fail_flag && !drive
    ##1 out_pin[1:0] == $past(do_pol[1:0]))
    else $error("timeout did not abort");
  chk_fail_event: assert property (tmo && state == S_OPEN && evmask[EV_OPEN_FAIL]
    |=> evt[EV_OPEN_FAIL])
    else $error("open failure not recorded");
  chk_close_fail: assert property (tmo && state == S_CLOSE && evmask[EV_CLOSE_FAIL]
    |=> evt[EV_CLOSE_FAIL])
    else $error("close failure not recorded");
  chk_trav_hold: assert property (objst_raw == ST_MID && trav_cnt < trav
    |=> objst_rep == $past(objst_rep))
    else $error("intermediate shown inside traverse time");
  chk_app_any_mode: assert property ($rose(app_open) && state == S_IDLE && !blocked
    && !soft_rst |=> state == S_OPEN)
    else $error("application open not executed");
  chk_block_inhibit: assert property (state == S_IDLE && blocked |=> state == S_IDLE)
    else $error("control while blocked");
  chk_close_perm: assert property (state == S_IDLE ##1 state == S_CLOSE |-> $past(perm))
    else $error("close without permission");
  chk_mask_gate: assert property ((evt & ~$past(evt) & ~$past(evmask)) == '0)
    else $error("unmasked event recorded");
  chk_ring_clear: assert property (clr_regs |=> wr_ptr == '0 && !oprec[0].valid)
    else $error("operation ring not cleared");
  chk_req_count: assert property (go_open && !clr_stats |=> cnt_open == $past(cnt_open) + 1'b1)
    else $error("open request not counted");
  chk_local_reject: assert property (!remote && (bus_open || bus_close) && state == S_IDLE
    && !app_open && !app_close
    && di_st[DI_LOC_CLOSE:DI_LOC_OPEN] == di_q[DI_LOC_CLOSE:DI_LOC_OPEN] |=> state == S_IDLE)
    else $error("bus command taken in local mode");
  chk_pin_polarity: assert property (##1 out_pin == $past(out_log ^ do_pol))
    else $error("output polarity wrong");

  cov_open_ok: cover property (state == S_OPEN && reached);
  cov_close_tmo: cover property (state == S_CLOSE && tmo);
  cov_rejected: cover property (reject);
endmodule : sog_object_ctrl

// [dv/sog_breaker_model.sv]
// breaker with two auxiliary status contacts, open at power up
`timescale 1ns/1ps
module sog_breaker_model #(
  parameter int TRAVEL = 20
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic cmd_open,
  input  wire logic cmd_close,
  input  wire logic stuck,
  output logic [1:0] st
);
  logic [7:0] cnt;
  logic       tgt;
  // both contacts low while the poles travel
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= 2'h1;
      cnt <= 8'h00;
      tgt <= 1'h0;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
      if (cnt == 8'h01) st <= tgt ? 2'h2 : 2'h1;
    end else if (!stuck && cmd_open && st == 2'h2) begin
      st <= 2'h0;
      cnt <= 8'(TRAVEL);
      tgt <= 1'h0;
    end else if (!stuck && cmd_close && st == 2'h1) begin
      st <= 2'h0;
      cnt <= 8'(TRAVEL);
      tgt <= 1'h1;
    end
  end
endmodule : sog_breaker_model

// [dv/test_sog_object_ctrl.sv]
// register-level tests of the object controller against a breaker model
`timescale 1ns/1ps
`define CK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module test_sog_object_ctrl;
  import sog_pkg::*;
  logic        clock = 1'h0, arst_n = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ext_block = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdat;
  logic        awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, sync_ok = 1'h0;
  logic        app_open = 1'h0, app_close = 1'h0, stuck = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, cmd_open_pin, cmd_close_pin, irq;
  logic [1:0]  bresp, rresp, rrsp, st;
  logic [7:2]  dib = 6'h00;
  logic [3:0]  relay;
  int          num_errors = 0, cmp_count = 0;
  always #5 clock = ~clock;
  sog_object_ctrl #(.CYC_PER_MS(4)) u_sog_object_ctrl (
    .clock(clock), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'h1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'h1), .di_pin({dib, st}),
    .app_open(app_open), .app_close(app_close), .sync_ok(sync_ok), .ext_block(ext_block),
    .cmd_open_pin(cmd_open_pin), .cmd_close_pin(cmd_close_pin), .relay(relay), .irq(irq));
  sog_breaker_model u_sog_breaker_model (.clock(clock), .arst_n(arst_n),
    .cmd_open(cmd_open_pin), .cmd_close(cmd_close_pin), .stuck(stuck), .st(st));
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid} <= 2'h3;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
  endtask : wr
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rdat = rdata;
    rrsp = rresp;
  endtask : rd
  // polls so that slow object motion is tolerated, then compares
  task chk(input string n, input logic [7:0] a, input logic [31:0] m, e);
    repeat (80) begin
      rd(a);
      if ((rdat & m) === e) break;
    end
    `CK(n, e, rdat & m)
  endtask : chk
  task pa(input logic c);
    app_close <= c;
    app_open <= !c;
    @(posedge clock);
    app_close <= 1'h0;
    app_open <= 1'h0;
  endtask : pa
  task end_sim;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #300000;
    num_errors++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'h1;
    @(posedge clock);
    chk("evmask", REG_EVMASK, 32'hFFFFFFFF, 32'h0);
    chk("dopol", REG_DOPOL, 32'hFFFFFFFF, 32'h0);
    rd(8'hFC);
    `CK("unmapped", RESP_SLVERR, rrsp)
    chk("open", REG_STATUS, 32'h3, 32'h1);
    $display("test reset done");
    wr(REG_EVMASK, 32'h3F);
    wr(REG_IRQMASK, 32'h3F);
    wr(REG_TERM, 32'h14);
    wr(REG_PL_CLS, 32'h14);
    wr(REG_PL_OPEN, 32'h14);
    dib[3] <= 1'h1;
    chk("loc close", REG_STATUS, 32'h3, 32'h2);
    dib[3] <= 1'h0;
    `CK("irq", 1'h1, irq)
    chk("evt close", REG_EVT, 32'h2, 32'h2);
    chk("evt clr", REG_EVT, 32'h3F, 32'h0);
    `CK("irq off", 1'h0, irq)
    $display("test local done");
    wr(REG_CTRL, 32'h1);
    dib[2] <= 1'h1;
    repeat (20) @(posedge clock);
    chk("reject", REG_EVT, 32'h20, 32'h20);
    chk("kept", REG_STATUS, 32'h3, 32'h2);
    dib[2] <= 1'h0;
    wr(REG_CMD, 32'h1);
    chk("bus open", REG_STATUS, 32'h3, 32'h1);
    $display("test remote done");
    // breaker refuses to move so the request must time out
    stuck <= 1'h1;
    wr(REG_CTRL, 32'h0);
    pa(1'h1);
    chk("fail", REG_STATUS, 32'h7, 32'h5);
    `CK("drop", 1'h0, cmd_close_pin)
    chk("evt fail", REG_EVT, 32'hA, 32'hA);
    chk("req cnt", REG_CNT_REQ, 32'hFFFFFFFF, 32'h00020001);
    chk("fail cnt", REG_CNT_FL, 32'hFFFFFFFF, 32'h00010000);
    $display("test fail done");
    stuck <= 1'h0;
    wr(REG_CMD, 32'h2);
    chk("bus local", REG_EVT, 32'h22, 32'h20);
    wr(REG_BLOCK, 32'h100);
    ext_block <= 8'h01;
    pa(1'h1);
    repeat (60) @(posedge clock);
    chk("blocked", REG_STATUS, 32'h3, 32'h1);
    ext_block <= 8'h00;
    wr(REG_CTRL, 32'h2);
    pa(1'h1);
    repeat (60) @(posedge clock);
    chk("no sync", REG_STATUS, 32'h3, 32'h1);
    sync_ok <= 1'h1;
    pa(1'h1);
    chk("sync", REG_STATUS, 32'h3, 32'h2);
    $display("test block done");
    wr(REG_OP_IDX, 32'h0);
    chk("op rec", REG_OP_DATA, 32'h40000, 32'h40000);
    wr(REG_CTRL, 32'hA);
    chk("op clr", REG_OP_DATA, 32'h40000, 32'h0);
    wr(REG_DIPOL, 32'h80);
    chk("di nc", REG_STATUS, 32'h8000, 32'h8000);
    wr(REG_DOPOL, 32'h4);
    repeat (2) @(posedge clock);
    `CK("relay nc", 1'h1, relay[0])
    wr(REG_DOPOL, 32'h0);
    wr(REG_ROUTE, 32'h9);
    wr(REG_TRAV, 32'h64);
    pa(1'h0);
    repeat (15) @(posedge clock);
    rd(REG_STATUS);
    `CK("trav hold", 32'h2, rdat & 32'h3)
    chk("app open", REG_STATUS, 32'h3, 32'h1);
    `CK("latched", 1'h1, relay[0])
    wr(REG_CTRL, 32'h21);
    repeat (2) @(posedge clock);
    `CK("unlatched", 1'h0, relay[0])
    $display("test io done");
    end_sim;
  end
endmodule : test_sog_object_ctrl
